// ### rtl/batch_pkg.sv
// shared constants and types for the batch sequence controller
package batch_pkg;

   // =========================================================
   // sizes
   localparam int NUM_SP = 8;
   localparam int IDX_W = 3;
   localparam int NUM_W = 4;
   localparam int WEIGHT_W = 20;
   localparam int TIMER_W = 16;
   localparam int NUM_OUT = 8;
   localparam int OUT_W = 3;
   localparam int PIN_COUNT = 5;

   // =========================================================
   // pin positions inside the synchroniser vector
   localparam int PIN_START = 0;
   localparam int PIN_RESET = 1;
   localparam int PIN_STOP = 2;
   localparam int PIN_PAUSE_N = 3;
   localparam int PIN_PERMIT = 4;

   // =========================================================
   // timing
   localparam int CLOCK_PERIOD_NS = 8;
   localparam int TENTH_SECOND_NS = 100_000_000;
   localparam int TENTH_CYCLES = TENTH_SECOND_NS / CLOCK_PERIOD_NS;
   localparam int PRESCALE_W = 24;

   // =========================================================
   // values
   localparam logic [NUM_W-1:0] NO_BRANCH = 4'h0;
   localparam logic [NUM_W-1:0] NUM_ONE = 4'h1;
   localparam logic [IDX_W-1:0] FIRST_STEP = 3'h0;
   localparam logic [IDX_W-1:0] LAST_STEP = 3'h7;
   localparam logic [WEIGHT_W-1:0] TARE_RESET = 20'h00000;

   // =========================================================
   // types
   typedef enum logic [2:0] {
      KIND_WEIGHT, KIND_RELATIVE, KIND_STANDSTILL, KIND_TIMER, KIND_PARALLEL, KIND_CONTINUOUS
   } kind_type;

   typedef enum {ST_IDLE, ST_RUN, ST_PAUSE_CMD, ST_PAUSE_PIN, ST_STOPPED} batch_state_type;

endpackage

// ### rtl/pin_sync_edge.sv
// two-stage synchroniser with edge detection for switch inputs
`timescale 1ns/100ps
module pin_sync_edge #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // raw pins
   input wire logic [WIDTH-1:0] async_in,
   // synchronised level and edges
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);

   logic [WIDTH-1:0] meta_reg, meta_next;
   logic [WIDTH-1:0] stable_reg, stable_next;
   logic [WIDTH-1:0] prev_reg, prev_next;

   always_comb begin
      meta_next = async_in;
      stable_next = meta_reg;
      prev_next = stable_reg;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta_reg <= '0;
         stable_reg <= '0;
         prev_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         stable_reg <= stable_next;
         prev_reg <= prev_next;
      end
   end

   assign level = stable_reg;
   assign rise = stable_reg & ~prev_reg;
   assign fall = ~stable_reg & prev_reg;

endmodule // pin_sync_edge

// ### rtl/batch_sequence_controller.sv
// batch sequencer: commands, step walk, setpoint outputs and pause gating
`timescale 1ns/100ps
module batch_sequence_controller #(
   parameter int TENTH_CYCLES = batch_pkg::TENTH_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // switch pins
   input wire logic start_pin,
   input wire logic reset_pin,
   input wire logic stop_pin,
   input wire logic pause_pin_n,
   input wire logic run_permit_input,
   // softkey and serial command pulses
   input wire logic start_cmd,
   input wire logic reset_cmd,
   input wire logic pause_cmd,
   input wire logic stop_cmd,
   // configuration
   input wire logic run_permit_assigned,
   input wire batch_pkg::kind_type sp_kind [batch_pkg::NUM_SP],
   input wire logic [batch_pkg::NUM_SP-1:0] sp_batch,
   input wire logic [batch_pkg::NUM_SP-1:0] sp_trip_lower,
   input wire logic [batch_pkg::NUM_SP-1:0] sp_use_net,
   input wire logic [batch_pkg::NUM_SP-1:0] relative_below_setpoint,
   input wire logic [batch_pkg::NUM_SP-1:0] tare_on_pass,
   input wire logic [batch_pkg::NUM_SP-1:0] sp_concur_type_one,
   input wire logic [batch_pkg::NUM_SP-1:0] sp_has_output,
   input wire logic signed [batch_pkg::WEIGHT_W-1:0] sp_value [batch_pkg::NUM_SP],
   input wire logic [batch_pkg::WEIGHT_W-1:0] hysteresis_band [batch_pkg::NUM_SP],
   input wire logic [batch_pkg::NUM_W-1:0] reference_setpoint_index [batch_pkg::NUM_SP],
   input wire logic [batch_pkg::NUM_W-1:0] sp_start_num [batch_pkg::NUM_SP],
   input wire logic [batch_pkg::NUM_W-1:0] sp_end_num [batch_pkg::NUM_SP],
   input wire logic [batch_pkg::NUM_W-1:0] sp_branch_num [batch_pkg::NUM_SP],
   input wire logic [batch_pkg::OUT_W-1:0] discrete_output_select [batch_pkg::NUM_SP],
   // weighing
   input wire logic signed [batch_pkg::WEIGHT_W-1:0] gross_weight,
   input wire logic standstill,
   // results
   output logic [batch_pkg::NUM_OUT-1:0] discrete_out_n,
   output logic tare_capture,
   output logic net_mode,
   output logic batch_running,
   output logic batch_paused,
   output logic batch_stopped,
   output logic [batch_pkg::IDX_W-1:0] step_index
);

   localparam int N = batch_pkg::NUM_SP;
   localparam int W = batch_pkg::WEIGHT_W;

   // =========================================================
   // pin synchronisation
   logic [batch_pkg::PIN_COUNT-1:0] pin_level, pin_rise, pin_fall;

   pin_sync_edge #(.WIDTH(batch_pkg::PIN_COUNT)) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .async_in({run_permit_input, pause_pin_n, stop_pin, reset_pin, start_pin}),
      .level(pin_level),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   logic permit, permit_lost, start_req, reset_req, stop_req, pause_req;

   always_comb begin
      permit = run_permit_assigned ? pin_level[batch_pkg::PIN_PERMIT] : 1'b1;
      permit_lost = run_permit_assigned && pin_fall[batch_pkg::PIN_PERMIT];
      start_req = (pin_rise[batch_pkg::PIN_START] || start_cmd) && permit;
      reset_req = (pin_rise[batch_pkg::PIN_RESET] || reset_cmd) && !permit;
      stop_req = pin_rise[batch_pkg::PIN_STOP] || stop_cmd || permit_lost;
      pause_req = pause_cmd || pin_fall[batch_pkg::PIN_PAUSE_N];
   end

   // =========================================================
   // weight, tare and tenth-second tick
   logic signed [W-1:0] tare_reg, tare_next;
   logic net_reg, net_next;
   logic tare_pulse_reg, tare_pulse_next;
   logic [batch_pkg::PRESCALE_W-1:0] prescale_reg, prescale_next;
   logic tick;
   logic signed [W-1:0] net_weight;

   always_comb begin
      net_weight = gross_weight - tare_reg;
      tick = (prescale_reg == batch_pkg::PRESCALE_W'(TENTH_CYCLES - 1));
      prescale_next = tick ? '0 : prescale_reg + 1'b1;
   end

   // =========================================================
   // per-setpoint evaluation
   batch_pkg::batch_state_type state_reg, state_next;
   logic [batch_pkg::IDX_W-1:0] step_reg, step_next;
   logic begin_reg, begin_next;
   logic first_reg, first_next;
   logic [N-1:0] met, sp_on, allow;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_sp
         logic signed [W:0] wsel, thr, top;
         logic [batch_pkg::NUM_W-1:0] ref_m1, start_m1, end_m1;
         logic hyst_reg, hyst_next;
         logic win_reg, win_next;
         logic [batch_pkg::TIMER_W-1:0] cnt_reg, cnt_next;
         logic start_hit, end_hit;

         always_comb begin
            ref_m1 = reference_setpoint_index[g] - batch_pkg::NUM_ONE;
            start_m1 = sp_start_num[g] - batch_pkg::NUM_ONE;
            end_m1 = sp_end_num[g] - batch_pkg::NUM_ONE;
            wsel = sp_use_net[g] ? (W+1)'(net_weight) : (W+1)'(gross_weight);
            thr = (W+1)'(sp_value[g]);
            if (sp_kind[g] == batch_pkg::KIND_RELATIVE) begin
               if (relative_below_setpoint[g]) begin
                  thr = (W+1)'(sp_value[ref_m1[batch_pkg::IDX_W-1:0]]) - thr;
               end else begin
                  thr = (W+1)'(sp_value[ref_m1[batch_pkg::IDX_W-1:0]]) + thr;
               end
            end
            top = (W+1)'(sp_value[g]) + signed'({1'b0, hysteresis_band[g]});
            if (sp_kind[g] == batch_pkg::KIND_STANDSTILL) begin
               met[g] = standstill;
            end else if (sp_trip_lower[g]) begin
               met[g] = wsel < thr;
            end else begin
               met[g] = wsel >= thr;
            end
            // band latch: set under value, clear over value plus band
            hyst_next = hyst_reg;
            if (wsel < (W+1)'(sp_value[g])) begin
               hyst_next = 1'b1;
            end else if (wsel > top) begin
               hyst_next = 1'b0;
            end
            start_hit = begin_reg && sp_start_num[g] != batch_pkg::NO_BRANCH
               && step_reg == start_m1[batch_pkg::IDX_W-1:0];
            end_hit = begin_reg && sp_end_num[g] != batch_pkg::NO_BRANCH
               && step_reg == end_m1[batch_pkg::IDX_W-1:0];
            win_next = win_reg;
            cnt_next = cnt_reg;
            if (state_reg == batch_pkg::ST_IDLE || end_hit) begin
               win_next = 1'b0;
            end else if (start_hit) begin
               win_next = 1'b1;
               cnt_next = '0;
            end else if (win_reg && tick && cnt_reg != '1) begin
               cnt_next = cnt_reg + 1'b1;
            end
            case (sp_kind[g])
               batch_pkg::KIND_TIMER: sp_on[g] = win_reg
                  && cnt_reg > sp_value[g][batch_pkg::TIMER_W-1:0];
               batch_pkg::KIND_PARALLEL: sp_on[g] = win_reg;
               batch_pkg::KIND_CONTINUOUS: sp_on[g] = hyst_reg;
               batch_pkg::KIND_STANDSTILL: sp_on[g] = 1'b0;
               default: sp_on[g] = sp_batch[g] && step_reg == g && !met[g];
            endcase
            case (state_reg)
               batch_pkg::ST_RUN: allow[g] = 1'b1;
               batch_pkg::ST_PAUSE_CMD: allow[g] = sp_kind[g] == batch_pkg::KIND_TIMER
                  || sp_kind[g] == batch_pkg::KIND_PARALLEL;
               batch_pkg::ST_PAUSE_PIN: allow[g] = sp_kind[g] == batch_pkg::KIND_PARALLEL
                  && sp_concur_type_one[g];
               default: allow[g] = 1'b0;
            endcase
         end

         always_ff @(posedge sys_clk) begin
            if (rst) begin
               hyst_reg <= 1'b0;
               win_reg <= 1'b0;
               cnt_reg <= '0;
            end else begin
               hyst_reg <= hyst_next;
               win_reg <= win_next;
               cnt_reg <= cnt_next;
            end
         end
      end
   endgenerate

   // =========================================================
   // sequencer
   logic cur_seq;
   logic [batch_pkg::NUM_W-1:0] branch_m1;

   always_comb begin
      state_next = state_reg;
      step_next = step_reg;
      begin_next = 1'b0;
      first_next = first_reg;
      tare_next = tare_reg;
      net_next = net_reg;
      tare_pulse_next = 1'b0;
      cur_seq = sp_batch[step_reg] && (sp_kind[step_reg] == batch_pkg::KIND_WEIGHT
         || sp_kind[step_reg] == batch_pkg::KIND_RELATIVE
         || sp_kind[step_reg] == batch_pkg::KIND_STANDSTILL);
      branch_m1 = sp_branch_num[step_reg] - batch_pkg::NUM_ONE;
      if (reset_req) begin
         state_next = batch_pkg::ST_IDLE;
         step_next = batch_pkg::FIRST_STEP;
      end else if (stop_req) begin
         if (state_reg != batch_pkg::ST_IDLE) begin
            state_next = batch_pkg::ST_STOPPED;
         end
      end else if (start_req) begin
         state_next = batch_pkg::ST_RUN;
         if (state_reg == batch_pkg::ST_IDLE) begin
            begin_next = 1'b1;
            first_next = 1'b1;
         end
      end else if (pause_req && state_reg == batch_pkg::ST_RUN) begin
         state_next = pause_cmd ? batch_pkg::ST_PAUSE_CMD : batch_pkg::ST_PAUSE_PIN;
      end else if (state_reg == batch_pkg::ST_PAUSE_PIN && pin_rise[batch_pkg::PIN_PAUSE_N]) begin
         state_next = batch_pkg::ST_RUN;
      end else if (state_reg == batch_pkg::ST_RUN && !begin_reg) begin
         first_next = 1'b0;
         if (!cur_seq || met[step_reg]) begin
            if (sp_kind[step_reg] == batch_pkg::KIND_STANDSTILL && tare_on_pass[step_reg]) begin
               tare_next = gross_weight;
               net_next = 1'b1;
               tare_pulse_next = 1'b1;
            end
            if (step_reg == batch_pkg::LAST_STEP) begin
               state_next = batch_pkg::ST_IDLE;
               step_next = batch_pkg::FIRST_STEP;
            end else begin
               step_next = step_reg + 1'b1;
               begin_next = 1'b1;
               first_next = 1'b1;
            end
         end else if (first_reg && sp_branch_num[step_reg] != batch_pkg::NO_BRANCH) begin
            step_next = branch_m1[batch_pkg::IDX_W-1:0];
            begin_next = 1'b1;
            first_next = 1'b1;
         end
      end
   end

   // =========================================================
   // output drive, active low
   logic [batch_pkg::NUM_OUT-1:0] dout_n_reg, dout_n_next;

   always_comb begin
      dout_n_next = '1;
      for (int i = 0; i < N; i++) begin
         if (sp_on[i] && allow[i] && sp_has_output[i]) begin
            dout_n_next[discrete_output_select[i]] = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= batch_pkg::ST_IDLE;
         step_reg <= batch_pkg::FIRST_STEP;
         begin_reg <= 1'b0;
         first_reg <= 1'b0;
         tare_reg <= batch_pkg::TARE_RESET;
         net_reg <= 1'b0;
         tare_pulse_reg <= 1'b0;
         prescale_reg <= '0;
         dout_n_reg <= '1;
      end else begin
         state_reg <= state_next;
         step_reg <= step_next;
         begin_reg <= begin_next;
         first_reg <= first_next;
         tare_reg <= tare_next;
         net_reg <= net_next;
         tare_pulse_reg <= tare_pulse_next;
         prescale_reg <= prescale_next;
         dout_n_reg <= dout_n_next;
      end
   end

   assign discrete_out_n = dout_n_reg;
   assign tare_capture = tare_pulse_reg;
   assign net_mode = net_reg;
   assign batch_running = state_reg == batch_pkg::ST_RUN;
   assign batch_paused = state_reg == batch_pkg::ST_PAUSE_CMD
      || state_reg == batch_pkg::ST_PAUSE_PIN;
   assign batch_stopped = state_reg == batch_pkg::ST_STOPPED;
   assign step_index = step_reg;

endmodule // batch_sequence_controller

// ### sim/operator_panel.sv
// operator switch model: momentary switches, stop loop, pause pin, actuator view
`timescale 1ns/100ps
module operator_panel (
   // clock
   input wire logic sys_clk,
   // switch pins
   output logic start_pin,
   output logic reset_pin,
   output logic stop_pin,
   output logic pause_pin_n,
   output logic run_permit_input,
   // actuators
   input wire logic [batch_pkg::NUM_OUT-1:0] discrete_out_n
);
   logic [batch_pkg::NUM_OUT-1:0] energised;
   assign energised = ~discrete_out_n;
   initial begin
      start_pin = 1'b0;
      reset_pin = 1'b0;
      stop_pin = 1'b0;
      pause_pin_n = 1'b1;
      run_permit_input = 1'b1;
   end
   // =========================================================
   // momentary press: held several cycles, one command expected
   task automatic press(input int idx);
      @(negedge sys_clk);
      if (idx == 0) start_pin = 1'b1;
      else if (idx == 1) reset_pin = 1'b1;
      else stop_pin = 1'b1;
      repeat (4) @(negedge sys_clk);
      start_pin = 1'b0;
      reset_pin = 1'b0;
      stop_pin = 1'b0;
      repeat (4) @(negedge sys_clk);
   endtask
   // stop loop: 0 = mushroom pushed in (open)
   task automatic set_permit(input logic closed);
      @(negedge sys_clk);
      run_permit_input = closed;
      repeat (6) @(negedge sys_clk);
   endtask
   task automatic set_pause(input logic level);
      @(negedge sys_clk);
      pause_pin_n = level;
      repeat (6) @(negedge sys_clk);
   endtask
endmodule // operator_panel

// ### sim/batch_properties.sv
// concurrent checks on the batch controller ports
`timescale 1ns/100ps
module batch_properties #(
   parameter int TENTH_CYCLES = 10
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic stop_pin,
   input wire logic run_permit_input,
   input wire logic start_cmd,
   input wire logic reset_cmd,
   input wire logic pause_cmd,
   input wire logic stop_cmd,
   input wire logic run_permit_assigned,
   input wire logic [batch_pkg::NUM_OUT-1:0] discrete_out_n,
   input wire logic batch_running,
   input wire logic batch_paused,
   input wire logic batch_stopped,
   input wire logic [batch_pkg::IDX_W-1:0] step_index
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   AST_STOP_DROPS: assert property (stop_cmd && batch_running && !reset_cmd |=>
      batch_stopped ##1 discrete_out_n == 8'hff) else $error("stop did not drop outputs");
   AST_PAUSE_TAKEN: assert property (pause_cmd && batch_running && !stop_cmd && !reset_cmd
      && !start_cmd |=> batch_paused) else $error("pause not taken");
   AST_RESET_FIRST: assert property (reset_cmd && run_permit_assigned && !run_permit_input
      && !$past(run_permit_input, 2) && !$past(run_permit_input, 3) |=>
      step_index == batch_pkg::FIRST_STEP && !batch_running && !batch_stopped)
      else $error("reset did not return to first step");
   AST_START_BLOCKED: assert property (start_cmd && run_permit_assigned && !run_permit_input
      && !$past(run_permit_input, 2) && !$past(run_permit_input, 3) && batch_stopped
      && !reset_cmd |=> batch_stopped) else $error("start taken with permit open");
   AST_STOP_WINS: assert property (stop_cmd && start_cmd && batch_running |=>
      batch_stopped) else $error("start beat stop");
   AST_RESUME_STEP: assert property (start_cmd && batch_paused && !stop_cmd && !reset_cmd
      && !$past(stop_pin, 2)
      && (!run_permit_assigned || ($past(run_permit_input, 2) && $past(run_permit_input, 3)))
      |=> batch_running && $stable(step_index)) else $error("resume lost step");
   AST_STOP_HOLDS_STEP: assert property (batch_stopped && $past(batch_stopped) |->
      $stable(step_index)) else $error("step moved while stopped");
   AST_IDLE_OUTPUTS_OFF: assert property ((!batch_running && !batch_paused) [*2] |->
      discrete_out_n == 8'hff) else $error("output active while halted");
   AST_NO_PERMIT_START: assert property (start_cmd && !run_permit_assigned && batch_stopped
      && !stop_cmd && !reset_cmd && !$past(stop_pin, 2) |=> batch_running)
      else $error("start refused without permit input");
endmodule // batch_properties
bind batch_sequence_controller batch_properties #(.TENTH_CYCLES(TENTH_CYCLES)) u_batch_properties (
   .sys_clk(sys_clk), .rst(rst), .stop_pin(stop_pin), .run_permit_input(run_permit_input),
   .start_cmd(start_cmd), .reset_cmd(reset_cmd), .pause_cmd(pause_cmd), .stop_cmd(stop_cmd),
   .run_permit_assigned(run_permit_assigned), .discrete_out_n(discrete_out_n),
   .batch_running(batch_running), .batch_paused(batch_paused), .batch_stopped(batch_stopped),
   .step_index(step_index));

// ### sim/tb_top.sv
// self-checking bench for the batch sequence controller
`timescale 1ns/100ps
`define CHECK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] cmd_vec = 4'h0;
   logic run_permit_assigned = 1'b1;
   logic signed [batch_pkg::WEIGHT_W-1:0] gross_weight = 20'h00000;
   batch_pkg::kind_type sp_kind [batch_pkg::NUM_SP];
   logic [batch_pkg::NUM_SP-1:0] sp_batch = 8'h05;
   logic [batch_pkg::NUM_SP-1:0] sp_has_output = 8'h07;
   logic [batch_pkg::NUM_SP-1:0] trip_lower = 8'h00;
   logic [batch_pkg::NUM_SP-1:0] use_net = 8'h00;
   logic [batch_pkg::NUM_SP-1:0] rel_below = 8'h00;
   logic [batch_pkg::NUM_SP-1:0] tare_pass = 8'h00;
   logic [batch_pkg::NUM_SP-1:0] type_one = 8'h00;
   logic standstill = 1'b0;
   logic tare_capture, net_mode;
   logic signed [batch_pkg::WEIGHT_W-1:0] sp_value [batch_pkg::NUM_SP];
   logic [batch_pkg::WEIGHT_W-1:0] band [batch_pkg::NUM_SP];
   logic [batch_pkg::NUM_W-1:0] ref_num [batch_pkg::NUM_SP];
   logic [batch_pkg::NUM_W-1:0] end_num [batch_pkg::NUM_SP];
   logic [batch_pkg::NUM_W-1:0] branch_num [batch_pkg::NUM_SP];
   logic [batch_pkg::NUM_W-1:0] start_num [batch_pkg::NUM_SP];
   logic [batch_pkg::OUT_W-1:0] out_sel [batch_pkg::NUM_SP];
   logic start_pin, reset_pin, stop_pin, pause_pin_n, run_permit_input;
   logic [batch_pkg::NUM_OUT-1:0] discrete_out_n;
   logic batch_running, batch_paused, batch_stopped;
   logic [batch_pkg::IDX_W-1:0] step_index;
   int miscompares = 0;
   int tests_run = 0;
   int tare_seen = 0;
   always #4 sys_clk = ~sys_clk;
   always @(negedge sys_clk) if (tare_capture === 1'b1) tare_seen++;
   // sp0 weight batch, sp1 parallel opened by sp0, sp2 weight batch
   initial begin
      for (int i = 0; i < batch_pkg::NUM_SP; i++) begin
         sp_kind[i] = batch_pkg::KIND_WEIGHT;
         sp_value[i] = 20'sh001f4;
         band[i] = 20'h00000;
         ref_num[i] = 4'h0;
         end_num[i] = 4'h0;
         branch_num[i] = 4'h0;
         start_num[i] = 4'h0;
         out_sel[i] = i[2:0];
      end
      sp_kind[1] = batch_pkg::KIND_PARALLEL;
      start_num[1] = batch_pkg::NUM_ONE;
      sp_value[0] = 20'sh00064;
   end
   batch_sequence_controller #(.TENTH_CYCLES(10)) u_batch_sequence_controller (
      .sys_clk(sys_clk), .rst(rst), .start_pin(start_pin), .reset_pin(reset_pin),
      .stop_pin(stop_pin), .pause_pin_n(pause_pin_n), .run_permit_input(run_permit_input),
      .start_cmd(cmd_vec[0]), .reset_cmd(cmd_vec[1]), .pause_cmd(cmd_vec[2]),
      .stop_cmd(cmd_vec[3]), .run_permit_assigned(run_permit_assigned), .sp_kind(sp_kind),
      .sp_batch(sp_batch), .sp_trip_lower(trip_lower), .sp_use_net(use_net),
      .relative_below_setpoint(rel_below), .tare_on_pass(tare_pass),
      .sp_concur_type_one(type_one), .sp_has_output(sp_has_output), .sp_value(sp_value),
      .hysteresis_band(band), .reference_setpoint_index(ref_num), .sp_start_num(start_num),
      .sp_end_num(end_num), .sp_branch_num(branch_num), .discrete_output_select(out_sel),
      .gross_weight(gross_weight), .standstill(standstill), .discrete_out_n(discrete_out_n),
      .tare_capture(tare_capture), .net_mode(net_mode),
      .batch_running(batch_running), .batch_paused(batch_paused),
      .batch_stopped(batch_stopped), .step_index(step_index));
   operator_panel u_operator_panel (
      .sys_clk(sys_clk), .start_pin(start_pin), .reset_pin(reset_pin), .stop_pin(stop_pin),
      .pause_pin_n(pause_pin_n), .run_permit_input(run_permit_input),
      .discrete_out_n(discrete_out_n));
   // =========================================================
   // tasks
   task automatic pulse(input logic [3:0] which);
      @(negedge sys_clk);
      cmd_vec = which;
      @(negedge sys_clk);
      cmd_vec = 4'h0;
      repeat (3) @(negedge sys_clk);
   endtask
   task automatic chk(input logic [2:0] st, input logic [7:0] outs, input logic [2:0] stp);
      `CHECK({batch_running, batch_paused, batch_stopped}, st)
      `CHECK(discrete_out_n, outs)
      `CHECK(step_index, stp)
   endtask
   task automatic end_sim;
      $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wait_step(input logic [2:0] s);
      int n;
      for (n = 0; n < 100 && step_index !== s; n++) @(negedge sys_clk);
      if (n == 100) begin
         miscompares++;
         end_sim();
      end
      repeat (3) @(negedge sys_clk);
   endtask
   // =========================================================
   // sequence
   initial begin
      repeat (10) @(negedge sys_clk);
      rst = 1'b0;
      chk(3'b000, 8'hff, 3'h0);
      // let the run permit level pass the synchroniser before the first start
      repeat (3) @(negedge sys_clk);
      pulse(4'h1);
      chk(3'b100, 8'hfc, 3'h0);
      pulse(4'h4);
      chk(3'b010, 8'hfd, 3'h0);
      pulse(4'h1);
      chk(3'b100, 8'hfc, 3'h0);
      u_operator_panel.set_pause(1'b0);
      chk(3'b010, 8'hff, 3'h0);
      u_operator_panel.set_pause(1'b1);
      chk(3'b100, 8'hfc, 3'h0);
      gross_weight = 20'sh00064;
      wait_step(3'h2);
      chk(3'b100, 8'hf9, 3'h2);
      u_operator_panel.press(2);
      chk(3'b001, 8'hff, 3'h2);
      pulse(4'h1);
      chk(3'b100, 8'hf9, 3'h2);
      pulse(4'h9);
      chk(3'b001, 8'hff, 3'h2);
      pulse(4'h2);
      chk(3'b001, 8'hff, 3'h2);
      u_operator_panel.set_permit(1'b0);
      pulse(4'h1);
      chk(3'b001, 8'hff, 3'h2);
      u_operator_panel.press(0);
      chk(3'b001, 8'hff, 3'h2);
      u_operator_panel.press(1);
      chk(3'b000, 8'hff, 3'h0);
      u_operator_panel.set_permit(1'b1);
      u_operator_panel.press(0);
      chk(3'b100, 8'hf9, 3'h2);
      pulse(4'h8);
      chk(3'b001, 8'hff, 3'h2);
      run_permit_assigned = 1'b0;
      u_operator_panel.set_permit(1'b0);
      chk(3'b001, 8'hff, 3'h2);
      pulse(4'h1);
      chk(3'b100, 8'hf9, 3'h2);
      pulse(4'h2);
      chk(3'b100, 8'hf9, 3'h2);
      // second recipe: configuration change, abort, then a fresh run
      run_permit_assigned = 1'b1;
      sp_kind = '{batch_pkg::KIND_STANDSTILL, batch_pkg::KIND_RELATIVE, batch_pkg::KIND_WEIGHT,
         batch_pkg::KIND_TIMER, batch_pkg::KIND_PARALLEL, batch_pkg::KIND_CONTINUOUS,
         batch_pkg::KIND_WEIGHT, batch_pkg::KIND_WEIGHT};
      sp_value = '{20'sh00000, 20'sh00064, 20'sh00000, 20'sh00005, 20'sh00000, 20'sh0012c,
         20'sh003e8, 20'shffc18};
      start_num = '{4'h0, 4'h0, 4'h0, 4'h2, 4'h2, 4'h0, 4'h0, 4'h0};
      band[5] = 20'h002bc;
      ref_num[1] = 4'h3;
      end_num[3] = 4'h5;
      branch_num[6] = 4'h8;
      sp_batch = 8'hc3;
      sp_has_output = 8'hff;
      trip_lower = 8'h82;
      use_net = 8'h02;
      rel_below = 8'h02;
      tare_pass = 8'h01;
      type_one = 8'h10;
      pulse(4'h2);
      chk(3'b000, 8'hff, 3'h0);
      u_operator_panel.set_permit(1'b1);
      pulse(4'h1);
      chk(3'b100, 8'hdf, 3'h0);
      standstill = 1'b1;
      wait_step(3'h1);
      chk(3'b100, 8'hcd, 3'h1);
      `CHECK(net_mode, 1'b1)
      u_operator_panel.set_pause(1'b0);
      chk(3'b010, 8'hef, 3'h1);
      pulse(4'h1);
      chk(3'b100, 8'hcd, 3'h1);
      u_operator_panel.set_pause(1'b1);
      repeat (60) @(negedge sys_clk);
      chk(3'b100, 8'hc5, 3'h1);
      gross_weight = 20'sh003e9;
      repeat (3) @(negedge sys_clk);
      chk(3'b100, 8'he5, 3'h1);
      gross_weight = 20'sh002bc;
      repeat (3) @(negedge sys_clk);
      chk(3'b100, 8'he5, 3'h1);
      gross_weight = 20'shfff38;
      wait_step(3'h7);
      chk(3'b100, 8'h4f, 3'h7);
      `CHECK(tare_seen, 1)
      end_sim();
   end
endmodule // tb_top
